// >>> rtl/cal_pkg.sv
package cal_pkg;

   // Bus geometry
   localparam int ADDR_W  = 16;
   localparam int DATA_W  = 32;
   localparam int STRB_W  = 4;
   localparam int FIELD_W = 15;
   localparam int RES_W   = 16;
   localparam int CAL_N   = 5;

   // Register byte addresses
   localparam logic [15:0] LOCK_OFF     = 16'h2230;
   localparam logic [15:0] HS_OFS_OFF   = 16'h2234;
   localparam logic [15:0] AUX_GAIN_OFF = 16'h2240;
   localparam logic [15:0] AUX_OFS_OFF  = 16'h2244;
   localparam logic [15:0] HS_GAIN_OFF  = 16'h2284;
   localparam logic [15:0] LP_GAIN_OFF  = 16'h228C;
   localparam logic [15:0] RESULT_OFF   = 16'h2300;

   // Slots of the calibration word array
   localparam int IX_LP_GAIN  = 0;
   localparam int IX_HS_GAIN  = 1;
   localparam int IX_AUX_GAIN = 2;
   localparam int IX_HS_OFS   = 3;
   localparam int IX_AUX_OFS  = 4;

   // Key and reset values
   localparam logic [31:0] UNLOCK_KEY  = 32'hDE87_A5AF;
   localparam logic [31:0] LOCK_RST    = 32'h0000_0000;
   localparam logic [14:0] GAIN_UNITY  = 15'h4000;
   localparam logic [14:0] GAIN_HALF   = 15'h2000;
   localparam logic [14:0] GAIN_MAX    = 15'h7FFF;
   localparam logic [14:0] GAIN_ZERO   = 15'h0000;
   localparam logic [14:0] OFS_ZERO    = 15'h0000;
   localparam logic [14:0] OFS_ONE_LSB = 15'h0004;
   localparam logic [14:0] OFS_NEG_QTR = 15'h7FFF;
   localparam logic [15:0] RES_MAX     = 16'hFFFF;
   localparam logic [15:0] RES_MIN     = 16'h0000;
   localparam logic [15:0] RES_ONE     = 16'h0001;

   // Arithmetic layout: 14 fraction bits of gain, 2 quarter bits
   localparam int SUM_W      = 21;
   localparam int PROD_W     = 37;
   localparam int GAIN_SHIFT = 16;
   localparam int OVF_LO     = 32;

   localparam logic [15:0] CAL_OFF [CAL_N] = '{LP_GAIN_OFF, HS_GAIN_OFF,
      AUX_GAIN_OFF, HS_OFS_OFF, AUX_OFS_OFF};
   localparam logic [14:0] CAL_RST [CAL_N] = '{GAIN_UNITY, GAIN_UNITY,
      GAIN_UNITY, OFS_ZERO, OFS_ZERO};

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CH_LP  = 2'h0,
      CH_HS  = 2'h1,
      CH_AUX = 2'h2
   } cal_chan_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h1,
      WR_RESP = 2'h2
   } cal_wr_state_t;

   typedef struct packed {
      logic             valid;
      cal_chan_t        chan;
      logic [RES_W-1:0] data;
   } cal_sample_t;

endpackage : cal_pkg

// >>> rtl/cal_adc_correct.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module cal_adc_correct
   import cal_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [STRB_W-1:0] wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire cal_sample_t       sample_in,
   output cal_sample_t            result_out
);

   // Word address match, byte offset bits ignored
   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] off
   );
      return a[ADDR_W-1:2] == off[ADDR_W-1:2];
   endfunction : hit

   // Byte-lane merge of a write into a stored word
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] m;
      m = old;
      for (int i = 0; i < STRB_W; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Per-channel word selection
   function automatic logic [FIELD_W-1:0] pick(
      input cal_chan_t          ch,
      input logic [FIELD_W-1:0] lp,
      input logic [FIELD_W-1:0] hs,
      input logic [FIELD_W-1:0] aux
   );
      case (ch)
         CH_LP:   return lp;
         CH_HS:   return hs;
         CH_AUX:  return aux;
         default: return lp;
      endcase
   endfunction : pick

   logic [DATA_W-1:0]  lock_reg;
   logic [FIELD_W-1:0] cal_reg [CAL_N];
   logic               awready_reg;
   logic               wready_reg;
   logic               bvalid_reg;
   logic [1:0]         bresp_reg;
   logic               arready_reg;
   logic               rvalid_reg;
   logic [1:0]         rresp_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic [ADDR_W-1:0]  waddr_reg;
   logic [DATA_W-1:0]  wdata_reg;
   logic [STRB_W-1:0]  wstrb_reg;
   cal_wr_state_t      wstate_reg;
   cal_wr_state_t      wstate_next;
   cal_sample_t        result_reg;

   wire logic               aw_take;
   wire logic               w_take;
   wire logic               b_done;
   wire logic               ar_take;
   wire logic               r_done;
   wire logic               wr_fire;
   wire logic               unlocked;
   wire logic               lock_we;
   wire logic [CAL_N-1:0]   cal_we;
   wire logic [CAL_N-1:0]   wr_cal_hit;
   wire logic [CAL_N-1:0]   rd_cal_hit;
   wire logic [DATA_W-1:0]  rd_acc [CAL_N+1];
   wire logic               wr_known;
   wire logic               rd_known;
   wire logic [DATA_W-1:0]  rd_word;

   // Channel handshakes
   assign aw_take = awvalid && awready_reg;
   assign w_take  = wvalid && wready_reg;
   assign b_done  = bvalid_reg && bready;
   assign ar_take = arvalid && arready_reg;
   assign r_done  = rvalid_reg && rready;

   // Write fires once both address and data are held
   assign wr_fire = !awready_reg && !wready_reg && (wstate_reg == WR_IDLE);
   assign unlocked = (lock_reg == UNLOCK_KEY);
   assign lock_we  = wr_fire && hit(waddr_reg, LOCK_OFF);
   assign wr_known = lock_we || (|wr_cal_hit);
   assign rd_known = hit(araddr, LOCK_OFF) || hit(araddr, RESULT_OFF)
                     || (|rd_cal_hit);

   // Calibration words, one slot per register
   assign rd_acc[0] = 32'h0000_0000;
   for (genvar g = 0; g < CAL_N; g++) begin : g_cal
      wire logic [DATA_W-1:0] merged;
      assign merged = merge({{(DATA_W-FIELD_W){1'b0}}, cal_reg[g]},
                            wdata_reg, wstrb_reg);
      assign wr_cal_hit[g] = wr_fire && hit(waddr_reg, CAL_OFF[g]);
      assign cal_we[g]     = wr_cal_hit[g] && unlocked;
      assign rd_cal_hit[g] = hit(araddr, CAL_OFF[g]);
      // Upper bits never stored, so they read zero
      assign rd_acc[g+1]   = rd_acc[g] | (rd_cal_hit[g] ?
         {{(DATA_W-FIELD_W){1'b0}}, cal_reg[g]} : 32'h0000_0000);
      // Storage, reset to unity gain or zero offset
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            cal_reg[g] <= CAL_RST[g];
         end else if (ce && cal_we[g]) begin
            cal_reg[g] <= merged[FIELD_W-1:0];
         end
      end
   end

   // Read word assembly
   assign rd_word = rd_acc[CAL_N]
      | (hit(araddr, LOCK_OFF) ? lock_reg : 32'h0000_0000)
      | (hit(araddr, RESULT_OFF) ?
         {{(DATA_W-RES_W){1'b0}}, result_reg.data} : 32'h0000_0000);

   // Password register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_reg <= LOCK_RST;
      end else if (ce && lock_we) begin
         lock_reg <= merge(lock_reg, wdata_reg, wstrb_reg);
      end
   end

   // Write address channel
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         awready_reg <= 1'b1;
         waddr_reg   <= 16'h0000;
      end else if (ce) begin
         if (aw_take) begin
            awready_reg <= 1'b0;
            waddr_reg   <= awaddr;
         end else if (b_done) begin
            awready_reg <= 1'b1;
         end
      end
   end

   // Write data channel
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wready_reg <= 1'b1;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else if (ce) begin
         if (w_take) begin
            wready_reg <= 1'b0;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
         end else if (b_done) begin
            wready_reg <= 1'b1;
         end
      end
   end

   // Write response state
   always_comb begin
      wstate_next = wstate_reg;
      case (wstate_reg)
         WR_IDLE: begin
            if (wr_fire) begin
               wstate_next = WR_RESP;
            end
         end
         WR_RESP: begin
            if (b_done) begin
               wstate_next = WR_IDLE;
            end
         end
         default: begin
            wstate_next = WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wstate_reg <= WR_IDLE;
      end else if (ce) begin
         wstate_reg <= wstate_next;
      end
   end

   // Write response; locked writes are dropped with OKAY
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read channel, data captured with the address
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else if (ce) begin
         if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= rd_known ? RESP_OKAY : RESP_SLVERR;
            rdata_reg   <= rd_word;
         end else if (r_done) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
         end
      end
   end

   // Correction datapath
   wire logic [FIELD_W-1:0]      gain_sel;
   wire logic [FIELD_W-1:0]      ofs_sel;
   wire logic signed [SUM_W-1:0] sum_q;
   wire logic signed [PROD_W-1:0] prod;
   wire logic [RES_W-1:0]        corr;

   assign gain_sel = pick(sample_in.chan, cal_reg[IX_LP_GAIN],
                          cal_reg[IX_HS_GAIN], cal_reg[IX_AUX_GAIN]);
   assign ofs_sel  = pick(sample_in.chan, OFS_ZERO,
                          cal_reg[IX_HS_OFS], cal_reg[IX_AUX_OFS]);
   // Raw in quarter steps plus signed offset
   assign sum_q = signed'({3'h0, sample_in.data, 2'h0})
                + signed'({{(SUM_W-FIELD_W){ofs_sel[FIELD_W-1]}},
                           ofs_sel});
   // Gain code over 0x4000, quarter bits dropped
   assign prod = PROD_W'(sum_q)
               * PROD_W'(signed'({1'b0, gain_sel}));
   // Zero gain, underflow and overflow clamps
   assign corr = (gain_sel == GAIN_ZERO) ? RES_MIN :
                 prod[PROD_W-1] ? RES_MIN :
                 (|prod[PROD_W-2:OVF_LO]) ? RES_MAX :
                 prod[OVF_LO-1:GAIN_SHIFT];

   // Result register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         result_reg <= '0;
      end else if (ce) begin
         result_reg.valid <= sample_in.valid;
         if (sample_in.valid) begin
            result_reg.chan <= sample_in.chan;
            result_reg.data <= corr;
         end
      end
   end

   // Outputs straight from flops
   assign awready    = awready_reg;
   assign wready     = wready_reg;
   assign bvalid     = bvalid_reg;
   assign bresp      = bresp_reg;
   assign arready    = arready_reg;
   assign rvalid     = rvalid_reg;
   assign rresp      = rresp_reg;
   assign rdata      = rdata_reg;
   assign result_out = result_reg;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_in_lp_unity;
      ce && sample_in.valid && sample_in.chan == CH_LP
         && cal_reg[IX_LP_GAIN] == GAIN_UNITY;
   endsequence

   sequence s_in_hs_plain;
      ce && sample_in.valid && sample_in.chan == CH_HS
         && cal_reg[IX_HS_OFS] == OFS_ZERO;
   endsequence

   sequence s_unlock_write;
      ce && wr_fire && unlocked && hit(waddr_reg, HS_GAIN_OFF)
         && wstrb_reg == '1;
   endsequence

   unity_pass_a: assert property (
      s_in_lp_unity |=> result_reg.valid
         && result_reg.data == $past(sample_in.data))
      else $error("unity gain altered the result");

   gain_zero_a: assert property (
      ce && sample_in.valid && gain_sel == GAIN_ZERO
         |=> result_reg.data == RES_MIN)
      else $error("zero gain did not zero the result");

   half_gain_a: assert property (
      s_in_hs_plain ##0 cal_reg[IX_HS_GAIN] == GAIN_HALF
         |=> result_reg.data == ($past(sample_in.data) >> 1))
      else $error("half gain wrong");

   hs_offset_a: assert property (
      ce && sample_in.valid && sample_in.chan == CH_HS
         && cal_reg[IX_HS_GAIN] == GAIN_UNITY
         && cal_reg[IX_HS_OFS] == OFS_ONE_LSB
         && sample_in.data != RES_MAX
         |=> result_reg.data == 16'($past(sample_in.data) + RES_ONE))
      else $error("offset of four quarters not one LSB");

   neg_quarter_a: assert property (
      ce && sample_in.valid && sample_in.chan == CH_AUX
         && cal_reg[IX_AUX_GAIN] == GAIN_UNITY
         && cal_reg[IX_AUX_OFS] == OFS_NEG_QTR
         && sample_in.data != RES_MIN
         |=> result_reg.data == 16'($past(sample_in.data) - RES_ONE))
      else $error("minus quarter offset wrong");

   sat_top_a: assert property (
      ce && sample_in.valid && gain_sel == GAIN_MAX
         && sample_in.data == RES_MAX && !ofs_sel[FIELD_W-1]
         |=> result_reg.data == RES_MAX)
      else $error("result did not saturate high");

   lock_guard_a: assert property (
      ce && wr_fire && !unlocked
         |=> $stable(cal_reg[IX_HS_GAIN]) && $stable(cal_reg[IX_AUX_OFS])
            && bvalid_reg)
      else $error("locked write changed a calibration word");

   unlock_write_a: assert property (
      s_unlock_write |=> cal_reg[IX_HS_GAIN] == $past(wdata_reg[FIELD_W-1:0])
         && bvalid_reg && bresp_reg == RESP_OKAY)
      else $error("unlocked write not stored");

   reserved_zero_a: assert property (
      ce && ar_take && hit(araddr, LP_GAIN_OFF)
         |=> rvalid_reg && rdata_reg[DATA_W-1:FIELD_W] == '0)
      else $error("reserved bits read nonzero");

endmodule : cal_adc_correct

// >>> tb/tb_adc_result_gain_offset_calibration.sv
`timescale 1ns/100ps
module tb_adc_result_gain_offset_calibration
   import cal_pkg::*;
;
   logic              clock;
   logic              arst_n;
   logic              ce;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [DATA_W-1:0] wdata;
   logic [STRB_W-1:0] wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [DATA_W-1:0] rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   cal_sample_t       sample_in;
   cal_sample_t       result_out;
   int                failures;
   int                n_compared;
   int                seed;
   logic [14:0]       g_sh [3];
   logic [14:0]       o_sh [3];
   logic [31:0]       lock_sh;
   logic [15:0]       last_res;
   logic [33:0]       exp_r [$];
   logic [1:0]        exp_b [$];
   logic [17:0]       exp_s [$];
   logic [14:0]       gcode [6] = '{15'h7FFF, 15'h2000, 15'h3FFF, 15'h0001,
                                    15'h4000, 15'h0000};
   logic [14:0]       ocode [5] = '{15'h3FFF, 15'h0001, 15'h7FFF, 15'h4000,
                                    15'h0004};
   logic [15:0]       rd_set [8] = '{LOCK_OFF, LP_GAIN_OFF, HS_GAIN_OFF,
      AUX_GAIN_OFF, HS_OFS_OFF, AUX_OFS_OFF, RESULT_OFF, 16'h2288};

   cal_adc_correct uut (
      .clock(clock), .arst_n(arst_n), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sample_in(sample_in), .result_out(result_out)
   );

   // Clock generation
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Comparison and bookkeeping
   task automatic check(input string what, input logic [33:0] seen,
                        input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   // Reference correction: offset, gain, saturation
   function automatic logic [15:0] model(input logic [1:0] ch,
                                         input logic [15:0] raw);
      longint q;
      longint p;
      q = longint'(raw) * 4 + longint'($signed(o_sh[ch]));
      p = q * longint'(g_sh[ch]);
      if (g_sh[ch] == GAIN_ZERO || p < 0) return RES_MIN;
      if (p >= 64'h0000_0001_0000_0000) return RES_MAX;
      return 16'(p >>> 16);
   endfunction : model

   // Expected read answer from the shadow state
   function automatic logic [33:0] rd_exp(input logic [15:0] a);
      case (a)
         LOCK_OFF:     return {RESP_OKAY, lock_sh};
         LP_GAIN_OFF:  return {RESP_OKAY, 17'h0_0000, g_sh[0]};
         HS_GAIN_OFF:  return {RESP_OKAY, 17'h0_0000, g_sh[1]};
         AUX_GAIN_OFF: return {RESP_OKAY, 17'h0_0000, g_sh[2]};
         HS_OFS_OFF:   return {RESP_OKAY, 17'h0_0000, o_sh[1]};
         AUX_OFS_OFF:  return {RESP_OKAY, 17'h0_0000, o_sh[2]};
         RESULT_OFF:   return {RESP_OKAY, 16'h0000, last_res};
         default:      return {RESP_SLVERR, 32'h0000_0000};
      endcase
   endfunction : rd_exp

   // Register write, calibration shadow updated only while unlocked
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d);
      logic [33:0] r;
      r = rd_exp(a);
      exp_b.push_back((a == RESULT_OFF) ? RESP_SLVERR : r[33:32]);
      if (a == LOCK_OFF) lock_sh = d;
      else if (lock_sh == UNLOCK_KEY) begin
         case (a)
            LP_GAIN_OFF:  g_sh[0] = d[14:0];
            HS_GAIN_OFF:  g_sh[1] = d[14:0];
            AUX_GAIN_OFF: g_sh[2] = d[14:0];
            HS_OFS_OFF:   o_sh[1] = d[14:0];
            AUX_OFS_OFF:  o_sh[2] = d[14:0];
            default:      ;
         endcase
      end
      @(posedge clock);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask : axi_write

   // Register read, expectation noted before the request
   task automatic axi_read(input logic [15:0] a);
      exp_r.push_back(rd_exp(a));
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask : axi_read

   // Sample stream, back to back when called in a row
   task automatic send(input logic [1:0] ch, input logic [15:0] raw);
      @(posedge clock);
      sample_in <= '{valid: 1'b1, chan: cal_chan_t'(ch), data: raw};
      last_res = model(ch, raw);
      exp_s.push_back({ch, last_res});
   endtask : send

   task automatic idle();
      @(posedge clock);
      sample_in.valid <= 1'b0;
      sample_in.data  <= 16'($random(seed));
   endtask : idle

   // Output watcher: oldest note against each answer
   always @(posedge clock) begin
      if (arst_n && bvalid && bready)
         check("bresp", 34'(bresp), 34'(exp_b.pop_front()));
      if (arst_n && rvalid && rready)
         check("read", {rresp, rdata}, exp_r.pop_front());
      if (arst_n && result_out.valid)
         check("result", 34'({result_out.chan, result_out.data}),
               34'(exp_s.pop_front()));
   end

   // Watchdog
   initial begin
      #500_000;
      failures++;
      summarize();
   end

   // Main sequence
   initial begin
      {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      sample_in = '0;
      ce = 1'b1;
      failures = 0;
      n_compared = 0;
      seed = 32'h3324_2bf3;
      g_sh = '{GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
      o_sh = '{OFS_ZERO, OFS_ZERO, OFS_ZERO};
      lock_sh = LOCK_RST;
      last_res = RES_MIN;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      // Reset values and decode
      foreach (rd_set[i]) axi_read(rd_set[i]);
      $display("test reset values done");
      // Writes while locked leave words alone
      axi_write(HS_GAIN_OFF, 32'h0000_2000);
      axi_read(HS_GAIN_OFF);
      send(CH_HS, 16'h1234);
      idle();
      $display("test locked write done");
      // Unlock, reserved bits dropped, refused targets
      axi_write(LOCK_OFF, UNLOCK_KEY);
      for (int i = 0; i < CAL_N; i++) begin
         axi_write(CAL_OFF[i], 32'hFFFF_8000 | 32'($random(seed)));
         axi_read(CAL_OFF[i]);
      end
      axi_write(RESULT_OFF, 32'h0000_5555);
      axi_write(16'h2288, 32'h0000_1111);
      axi_read(16'h2288);
      $display("test unlocked access done");
      // Gain codes, zero included
      foreach (gcode[i]) begin
         axi_write(LP_GAIN_OFF, {17'h0_0000, gcode[i]});
         send(CH_LP, 16'hFFFF);
         send(CH_LP, 16'($random(seed)));
         idle();
      end
      $display("test gain codes done");
      // Offset codes with unity gain
      axi_write(HS_GAIN_OFF, {17'h0_0000, GAIN_UNITY});
      axi_write(AUX_GAIN_OFF, {17'h0_0000, GAIN_UNITY});
      foreach (ocode[i]) begin
         axi_write(HS_OFS_OFF, {17'h0_0000, ocode[i]});
         axi_write(AUX_OFS_OFF, {17'h0_0000, ocode[i]});
         send(CH_HS, 16'h0000);
         send(CH_HS, 16'h8000);
         send(CH_AUX, 16'hFFFF);
         idle();
      end
      // Half gain on the high speed channel
      axi_write(HS_OFS_OFF, {17'h0_0000, OFS_ZERO});
      axi_write(HS_GAIN_OFF, {17'h0_0000, GAIN_HALF});
      send(CH_HS, 16'($random(seed)));
      idle();
      $display("test offset codes done");
      // Random words and back-to-back samples
      repeat (30) begin
         axi_write(CAL_OFF[($random(seed) & 32'h7FFF_FFFF) % CAL_N],
                   32'($random(seed)));
         repeat (4) send(2'(($random(seed) & 32'h7FFF_FFFF) % 3),
                         16'($random(seed)));
         idle();
      end
      $display("test random stream done");
      // Clock enable low freezes the result register
      @(posedge clock);
      ce        <= 1'b0;
      sample_in <= '{valid: 1'b1, chan: CH_LP, data: 16'($random(seed))};
      repeat (3) @(posedge clock);
      ce              <= 1'b1;
      sample_in.valid <= 1'b0;
      axi_read(RESULT_OFF);
      $display("test clock enable done");
      // Relock protects the words
      axi_write(LOCK_OFF, 32'h0000_0000);
      axi_write(LP_GAIN_OFF, 32'h0000_1234);
      axi_read(LP_GAIN_OFF);
      axi_read(LOCK_OFF);
      $display("test relock done");
      repeat (5) @(posedge clock);
      if (exp_r.size() + exp_b.size() + exp_s.size() != 0) failures++;
      summarize();
   end
endmodule : tb_adc_result_gain_offset_calibration
